// *** src/rfb_top.sv ***
// Overview of operation
// RL1 - read-only 4-bit trigger to clock phase
// RL2 - 128-byte store, two independent simultaneous ports
// RL3 - addresses 0x00 to 0x7F, one frame
// RL4 - access conflicts raise underrun interrupt six
// RL5 - writing past 127 octets raises underrun
// RL6 - host access only with regulator on, clock
// RL7 - contents kept until write, receive, sleep, reset
// RL8 - frame during host read raises underrun
// RL9 - host reads fast enough, checks checksum
// RL10 - host parks state after frame done
// RL11 - ack-wait receptions in retry mode not stored
// RL12 - sleep entry wipes store, others keep it
// RL13 - store length, payload, append receive metadata
// RL14 - length byte at address zero randomly read
// RL15 - auto checksum replaces transmitted FCS field
// RL16 - frames of length one accepted
// RL17 - host and baseband keep separate counters
// RL18 - violations flagged only in sequential mode
// RL19 - host waits 32 us, reads below rate
// RL20 - transmit write violation when host counter lags
// RL21 - receive underrun valid 64 us after start
// RL22 - host places first byte within 176 us
// RL23 - underrun latched until status read
//
// Decided for this implementation: the register addresses and the Avalon-MM interface to the registers.
`timescale 1ns/100ps
module rfb_top #(
  parameter int unsigned RX_VALID_CYCLES = rfb_pkg::RX_VALID_CYC
) (
  input wire logic clk, // core clock, 250 MHz
  input wire logic reset, // synchronous reset, active high
  input wire logic [4:0] avs_address, // register byte address
  input wire logic avs_read, // bus read request
  input wire logic avs_write, // bus write request
  input wire logic [31:0] avs_writedata, // bus write data
  output logic [31:0] avs_readdata, // bus read data
  output logic avs_waitrequest, // bus stall
  input wire logic sleep_state, // device in either sleep state
  input wire logic power_on_state, // device in power-on state
  input wire logic mclk_1mhz_sel, // master clock output runs at 1 MHz
  input wire logic tx_trigger_pin, // transmit trigger pin
  input wire logic master_clock_out, // master clock output pin
  input wire logic bb_rx_start, // receive frame begins
  input wire logic bb_rx_we, // receive byte strobe
  input wire logic [7:0] bb_rx_data, // receive byte
  input wire logic bb_rx_meta_we, // receive frame metadata strobe
  input wire logic [7:0] link_quality_value, // link quality of frame
  input wire logic [7:0] energy_level_value, // energy level of frame
  input wire logic [7:0] rx_status_value, // receive status of frame
  input wire logic auto_retry_tx_mode, // auto retry transmit mode
  input wire logic bb_ack_wait, // waiting for acknowledgement
  input wire logic bb_tx_start, // transmit frame begins
  input wire logic bb_tx_busy, // transmission in progress
  input wire logic bb_tx_re, // transmit byte fetch strobe
  output logic [7:0] bb_tx_data, // transmit byte
  output logic buffer_underrun_irq, // latched underrun interrupt
  output logic [3:0] trigger_phase_count // trigger phase measurement
);
  logic waitreq_q;
  logic [31:0] rdata_q;
  logic auto_fcs_q;
  logic [7:0] host_ptr_q;
  logic [6:0] sram_addr_q;
  logic [7:0] bb_ptr_q;
  logic [15:0] fcs_q;
  logic [7:0] quality_q, energy_q, rxst_q;
  logic ur_q;
  logic reading_q;
  logic rx_active_q;
  logic [rfb_pkg::RX_TMR_W-1:0] rx_timer_q;
  logic sleep_q;
  logic [7:0] tx_byte_q;
  logic req, start, acc, host_ok, clear;
  logic sel_fb, sel_sram;
  logic [7:0] ra_data, rb_data, len_data;
  logic [6:0] ra_addr;
  logic wa_en, wb_en;
  logic [6:0] wa_addr;
  logic [7:0] meta_idx;
  logic [7:0] fb_byte;
  logic rx_store;
  logic fb_wr, fb_rd, ovf_evt, txv_evt, rxv_evt, ovw_evt, ur_set, ur_clr;
  logic [31:0] rd_d;

  function automatic logic [15:0] fcs_step(input logic [15:0] c, input logic [7:0] d);
    logic [15:0] r;
    r = c;
    for (int i = 0; i < 8; i++) begin
      r = (r[0] ^ d[i]) ? ((r >> 1) ^ rfb_pkg::FCS_POLY) : (r >> 1);
    end
    return r;
  endfunction

  assign req = avs_read || avs_write;
  assign start = req && waitreq_q;
  assign acc = req && !waitreq_q;
  assign sel_fb = avs_address == rfb_pkg::REG_FB_DATA;
  assign sel_sram = avs_address == rfb_pkg::REG_SRAM_DATA;
  // RL6 host access gate
  assign host_ok = !sleep_state && (!power_on_state || mclk_1mhz_sel);
  // RL12 wipe on sleep entry
  assign clear = sleep_state && !sleep_q;

  // RL2 dual-port store
  rfb_store u_store (
    .clk(clk),
    .reset(reset),
    .clear(clear),
    .wa_en(wa_en),
    .wa_addr(wa_addr),
    .wa_data(avs_writedata[7:0]),
    .wb_en(wb_en),
    .wb_addr(bb_ptr_q[6:0]),
    .wb_data(bb_rx_data),
    .ra_addr(ra_addr),
    .ra_data(ra_data),
    .rb_addr(bb_ptr_q[6:0]),
    .rb_data(rb_data),
    .len_data(len_data)
  );

  rfb_phase u_phase (
    .clk(clk),
    .reset(reset),
    .tx_trigger_pin(tx_trigger_pin),
    .master_clock_out(master_clock_out),
    .trigger_phase_count(trigger_phase_count)
  );

  // RL3 seven-bit store addressing
  assign ra_addr = sel_sram ? sram_addr_q : host_ptr_q[6:0];
  assign wa_addr = sel_sram ? sram_addr_q : host_ptr_q[6:0];
  assign fb_wr = acc && avs_write && sel_fb && host_ok;
  assign fb_rd = acc && avs_read && sel_fb && host_ok;
  // RL5 no store beyond the last address
  assign wa_en = (fb_wr && host_ptr_q <= rfb_pkg::FB_LAST_ADDR) ||
                 (acc && avs_write && sel_sram && host_ok);
  // RL11 ack-wait receptions in auto retry mode are evaluated only
  assign rx_store = bb_rx_we && !(auto_retry_tx_mode && bb_ack_wait);
  assign wb_en = rx_store && bb_ptr_q <= rfb_pkg::FB_LAST_ADDR;

  // RL13 metadata appended after the frame
  assign meta_idx = host_ptr_q - len_data - 8'h01;
  always_comb begin
    if (host_ptr_q <= len_data && host_ptr_q <= rfb_pkg::FB_LAST_ADDR) begin
      fb_byte = ra_data;
    end else if (meta_idx == 8'h00) begin
      fb_byte = quality_q;
    end else if (meta_idx == 8'h01) begin
      fb_byte = energy_q;
    end else if (meta_idx == 8'h02) begin
      fb_byte = rxst_q;
    end else begin
      fb_byte = 8'h00;
    end
  end

  // RL18 sequential-mode violations only
  assign ovf_evt = fb_wr && host_ptr_q > rfb_pkg::FB_LAST_ADDR;
  // RL20 host write counter not ahead of transmit
  assign txv_evt = fb_wr && bb_tx_busy && host_ptr_q <= bb_ptr_q;
  // RL21 receive read violation after hold-off
  assign rxv_evt = fb_rd && rx_active_q && host_ptr_q >= bb_ptr_q && rx_timer_q == '0;
  // RL8 new frame during host read
  assign ovw_evt = bb_rx_start && reading_q;
  // RL4 underrun sources
  assign ur_set = ovf_evt || txv_evt || rxv_evt || ovw_evt;
  assign ur_clr = acc && avs_read && avs_address == rfb_pkg::REG_STATUS;

  always_comb begin
    rd_d = rfb_pkg::UNMAPPED_VALUE;
    case (avs_address)
      rfb_pkg::REG_CTRL: rd_d[rfb_pkg::CTRL_AUTO_FCS_BIT] = auto_fcs_q;
      rfb_pkg::REG_STATUS: begin
        rd_d[rfb_pkg::STAT_HOST_OK_BIT] = host_ok;
        rd_d[rfb_pkg::STAT_READING_BIT] = reading_q;
        rd_d[rfb_pkg::STAT_UR_BIT] = ur_q;
      end
      rfb_pkg::REG_PHASE: rd_d[3:0] = trigger_phase_count;
      rfb_pkg::REG_FB_ADDR: rd_d[7:0] = host_ptr_q;
      rfb_pkg::REG_FB_DATA: rd_d[7:0] = host_ok ? fb_byte : 8'h00;
      rfb_pkg::REG_SRAM_ADDR: rd_d[6:0] = sram_addr_q;
      // RL14 random read sees length at zero
      rfb_pkg::REG_SRAM_DATA: rd_d[7:0] = host_ok ? ra_data : 8'h00;
      default: rd_d = rfb_pkg::UNMAPPED_VALUE;
    endcase
  end

  // bus handshake: one stall cycle, then answer
  always_ff @(posedge clk) begin
    if (reset) begin
      waitreq_q <= 1'b1;
      rdata_q <= 32'h0000_0000;
    end else begin
      waitreq_q <= !start;
      if (start) begin
        rdata_q <= rd_d;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      auto_fcs_q <= rfb_pkg::CTRL_AUTO_FCS_RST;
      sram_addr_q <= 7'h00;
    end else if (acc && avs_write) begin
      if (avs_address == rfb_pkg::REG_CTRL) begin
        auto_fcs_q <= avs_writedata[rfb_pkg::CTRL_AUTO_FCS_BIT];
      end
      if (avs_address == rfb_pkg::REG_SRAM_ADDR) begin
        sram_addr_q <= avs_writedata[6:0];
      end
    end
  end

  // RL17 host address counter
  always_ff @(posedge clk) begin
    if (reset || clear) begin
      host_ptr_q <= 8'h00;
    end else if (acc && avs_write && avs_address == rfb_pkg::REG_FB_ADDR) begin
      host_ptr_q <= avs_writedata[7:0];
    end else if ((fb_wr || fb_rd) && host_ptr_q != 8'hff) begin
      host_ptr_q <= host_ptr_q + 8'h01;
    end
  end

  // sequential read in progress until metadata consumed
  always_ff @(posedge clk) begin
    if (reset || clear) begin
      reading_q <= 1'b0;
    end else if (acc && avs_write && avs_address == rfb_pkg::REG_FB_ADDR) begin
      reading_q <= 1'b0;
    end else if (fb_rd) begin
      reading_q <= host_ptr_q < len_data + rfb_pkg::META_COUNT;
    end
  end

  // RL17 baseband address counter
  always_ff @(posedge clk) begin
    if (reset || clear) begin
      bb_ptr_q <= 8'h00;
    end else if (bb_rx_start || bb_tx_start) begin
      bb_ptr_q <= 8'h00;
    end else if ((rx_store || bb_tx_re) && bb_ptr_q != 8'hff) begin
      bb_ptr_q <= bb_ptr_q + 8'h01;
    end
  end

  always_ff @(posedge clk) begin
    if (reset || clear) begin
      rx_active_q <= 1'b0;
      rx_timer_q <= '0;
    end else if (bb_rx_start) begin
      rx_active_q <= 1'b1;
      rx_timer_q <= rfb_pkg::RX_TMR_W'(RX_VALID_CYCLES);
    end else begin
      if (bb_rx_meta_we) begin
        rx_active_q <= 1'b0;
      end
      if (rx_timer_q != '0) begin
        rx_timer_q <= rx_timer_q - 1'b1;
      end
    end
  end

  // RL13 receive metadata capture
  always_ff @(posedge clk) begin
    if (reset || clear) begin
      quality_q <= 8'h00;
      energy_q <= 8'h00;
      rxst_q <= 8'h00;
    end else if (bb_rx_meta_we && !(auto_retry_tx_mode && bb_ack_wait)) begin
      quality_q <= link_quality_value;
      energy_q <= energy_level_value;
      rxst_q <= rx_status_value;
    end
  end

  // RL15 checksum substitution on fetch
  always_ff @(posedge clk) begin
    if (reset) begin
      fcs_q <= rfb_pkg::FCS_INIT;
      tx_byte_q <= 8'h00;
    end else if (bb_tx_start) begin
      fcs_q <= rfb_pkg::FCS_INIT;
    end else if (bb_tx_re) begin
      // RL16 short frames keep their bytes
      if (auto_fcs_q && len_data >= rfb_pkg::FCS_MIN_LEN && bb_ptr_q == len_data - 8'h01) begin
        tx_byte_q <= fcs_q[7:0];
      end else if (auto_fcs_q && len_data >= rfb_pkg::FCS_MIN_LEN && bb_ptr_q == len_data) begin
        tx_byte_q <= fcs_q[15:8];
      end else begin
        tx_byte_q <= rb_data;
      end
      if (bb_ptr_q != 8'h00 && bb_ptr_q + 8'h02 <= len_data) begin
        fcs_q <= fcs_step(fcs_q, rb_data);
      end
    end
  end

  // RL23 latched until status read, set wins
  always_ff @(posedge clk) begin
    if (reset) begin
      ur_q <= 1'b0;
    end else if (ur_set) begin
      ur_q <= 1'b1;
    end else if (ur_clr) begin
      ur_q <= 1'b0;
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      sleep_q <= 1'b0;
    end else begin
      sleep_q <= sleep_state;
    end
  end

  assign avs_readdata = rdata_q;
  assign avs_waitrequest = waitreq_q;
  assign bb_tx_data = tx_byte_q;
  assign buffer_underrun_irq = ur_q;

  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);

  sequence fb_write_s;
    acc && avs_write && sel_fb && host_ok;
  endsequence
  sequence status_read_s;
    acc && avs_read && avs_address == rfb_pkg::REG_STATUS;
  endsequence

  bus_answer_a: assert property (start |=> !avs_waitrequest ##1 avs_waitrequest)
    else $error("bus answer not one cycle after request");
  overflow_flag_a: assert property ((fb_write_s and host_ptr_q > 8'h7f) |=> buffer_underrun_irq) // RL5
    else $error("overflow did not raise underrun");
  tx_violation_a: assert property (
    (fb_write_s and bb_tx_busy && host_ptr_q <= bb_ptr_q) |=> buffer_underrun_irq) // RL20
    else $error("transmit write violation missed");
  overwrite_flag_a: assert property (bb_rx_start && reading_q |=> buffer_underrun_irq) // RL8
    else $error("overwrite during read not flagged");
  ur_latch_a: assert property (buffer_underrun_irq && !ur_clr |=> buffer_underrun_irq) // RL23
    else $error("underrun dropped before status read");
  ur_clear_a: assert property ((status_read_s and !ur_set) |=> !buffer_underrun_irq) // RL23
    else $error("underrun not cleared by status read");
  sleep_wipe_a: assert property ($rose(sleep_state) |=> len_data == 8'h00 && quality_q == 8'h00) // RL12
    else $error("store not wiped on sleep entry");
  ack_wait_a: assert property (
    bb_rx_we && auto_retry_tx_mode && bb_ack_wait && !bb_rx_start && !bb_tx_start && !bb_tx_re
      && !clear |=> $stable(bb_ptr_q)) // RL11
    else $error("ack-wait reception was stored");
  rx_holdoff_a: assert property (bb_rx_start && !clear |=> rx_timer_q != '0 && !rxv_evt) // RL21
    else $error("receive underrun not held off");
  host_gate_a: assert property (
    acc && avs_write && sel_fb && !host_ok && !clear |=> $stable(host_ptr_q)) // RL6
    else $error("host access taken while blocked");
endmodule

// *** src/rfb_pkg.sv ***
package rfb_pkg;
  // clock and timing
  localparam int unsigned CLK_NS = 4;
  localparam int unsigned RX_VALID_NS = 64000;
  localparam int unsigned RX_VALID_CYC = (RX_VALID_NS + CLK_NS - 1) / CLK_NS;
  localparam int unsigned MCLK_NS = 1000;
  localparam int unsigned MCLK_CYC = MCLK_NS / CLK_NS;
  localparam int unsigned PHASE_STEPS = 16;
  localparam int unsigned RX_TMR_W = 15;
  // storage layout
  localparam int unsigned FB_DEPTH = 128;
  localparam int unsigned FB_AW = 7;
  localparam logic [7:0] FB_LAST_ADDR = 8'h7f;
  localparam logic [6:0] FB_LEN_ADDR = 7'h00;
  localparam logic [7:0] FCS_MIN_LEN = 8'h02;
  // register byte offsets
  localparam logic [4:0] REG_CTRL = 5'h00;
  localparam logic [4:0] REG_STATUS = 5'h04;
  localparam logic [4:0] REG_PHASE = 5'h08;
  localparam logic [4:0] REG_FB_ADDR = 5'h0c;
  localparam logic [4:0] REG_FB_DATA = 5'h10;
  localparam logic [4:0] REG_SRAM_ADDR = 5'h14;
  localparam logic [4:0] REG_SRAM_DATA = 5'h18;
  // fields and reset values
  localparam int unsigned CTRL_AUTO_FCS_BIT = 0;
  localparam int unsigned STAT_HOST_OK_BIT = 0;
  localparam int unsigned STAT_READING_BIT = 1;
  localparam int unsigned STAT_UR_BIT = 6;
  localparam logic CTRL_AUTO_FCS_RST = 1'b0;
  localparam logic [31:0] UNMAPPED_VALUE = 32'h0000_0000;
  // frame check sequence
  localparam logic [15:0] FCS_POLY = 16'h8408;
  localparam logic [15:0] FCS_INIT = 16'h0000;
  localparam logic [7:0] META_COUNT = 8'h03;
endpackage

// *** src/rfb_store.sv ***
`timescale 1ns/100ps
module rfb_store (
  input wire logic clk, // core clock
  input wire logic reset, // synchronous reset
  input wire logic clear, // wipe all entries
  input wire logic wa_en, // host write enable
  input wire logic [6:0] wa_addr, // host write address
  input wire logic [7:0] wa_data, // host write byte
  input wire logic wb_en, // baseband write enable
  input wire logic [6:0] wb_addr, // baseband write address
  input wire logic [7:0] wb_data, // baseband write byte
  input wire logic [6:0] ra_addr, // host read address
  output logic [7:0] ra_data, // host read byte
  input wire logic [6:0] rb_addr, // baseband read address
  output logic [7:0] rb_data, // baseband read byte
  output logic [7:0] len_data // byte at address zero
);
  logic [7:0] mem_q [rfb_pkg::FB_DEPTH];

  // RL7 held until rewritten, wiped on sleep entry or reset
  // two independent ports; baseband wins a same-entry collision
  for (genvar i = 0; i < rfb_pkg::FB_DEPTH; i++) begin : g_entry
    always_ff @(posedge clk) begin
      if (reset || clear) begin
        mem_q[i] <= 8'h00;
      end else if (wb_en && wb_addr == 7'(i)) begin
        mem_q[i] <= wb_data;
      end else if (wa_en && wa_addr == 7'(i)) begin
        mem_q[i] <= wa_data;
      end
    end
  end

  assign ra_data = mem_q[ra_addr];
  assign rb_data = mem_q[rb_addr];
  assign len_data = mem_q[rfb_pkg::FB_LEN_ADDR];
endmodule

// *** src/rfb_phase.sv ***
`timescale 1ns/100ps
module rfb_phase (
  input wire logic clk, // core clock
  input wire logic reset, // synchronous reset
  input wire logic tx_trigger_pin, // asynchronous trigger pin
  input wire logic master_clock_out, // 1 MHz clock pin, asynchronous
  output logic [3:0] trigger_phase_count // phase in sixteenths of a microsecond
);
  logic [2:0] trig_sync_q;
  logic [2:0] mclk_sync_q;
  logic [7:0] since_q;
  logic [11:0] scaled;

  always_ff @(posedge clk) begin
    if (reset) begin
      trig_sync_q <= 3'h0;
      mclk_sync_q <= 3'h0;
    end else begin
      trig_sync_q <= {trig_sync_q[1:0], tx_trigger_pin};
      mclk_sync_q <= {mclk_sync_q[1:0], master_clock_out};
    end
  end

  // cycles since the last master clock rising edge
  always_ff @(posedge clk) begin
    if (reset) begin
      since_q <= 8'h00;
    end else if (mclk_sync_q[1] && !mclk_sync_q[2]) begin
      since_q <= 8'h00;
    end else if (since_q != 8'hff) begin
      since_q <= since_q + 8'h01;
    end
  end

  assign scaled = 12'(({4'h0, since_q} * 12'(rfb_pkg::PHASE_STEPS)) / 12'(rfb_pkg::MCLK_CYC));

  // RL1 phase capture
  always_ff @(posedge clk) begin
    if (reset) begin
      trigger_phase_count <= 4'h0;
    end else if (trig_sync_q[1] && !trig_sync_q[2]) begin
      trigger_phase_count <= (scaled > 12'h00f) ? 4'hf : scaled[3:0];
    end
  end
endmodule

// *** dv/rfb_host_model.sv ***
`timescale 1ns/100ps
module rfb_host_model (
  input wire logic clk, // core clock
  output logic [4:0] avs_address, // register address
  output logic avs_read, // read request
  output logic avs_write, // write request
  output logic [31:0] avs_writedata, // write data
  input wire logic [31:0] avs_readdata, // read data
  input wire logic avs_waitrequest // slave stall
);
  initial begin
    avs_address = 5'h00;
    avs_read = 1'b0;
    avs_write = 1'b0;
    avs_writedata = 32'h0000_0000;
  end
  // one word per access at core rate, far above the air rate
  task automatic xfer(input logic wr, input logic [4:0] a, input logic [31:0] d,
    output logic [31:0] q);
    avs_address <= a;
    avs_write <= wr;
    avs_read <= !wr;
    avs_writedata <= d;
    @(posedge clk);
    while (avs_waitrequest !== 1'b0) @(posedge clk);
    q = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
    avs_writedata <= ~d;
    @(posedge clk);
  endtask
endmodule

// *** dv/rfb_top_tb.sv ***
`timescale 1ns/100ps
module rfb_top_tb;
  localparam int unsigned HOLD = 40;
  logic clk, reset, avs_read, avs_write, avs_waitrequest, sleep_state, power_on_state;
  logic mclk_1mhz_sel, tx_trigger_pin, master_clock_out, bb_rx_start, bb_rx_we, bb_rx_meta_we;
  logic auto_retry_tx_mode, bb_ack_wait, bb_tx_start, bb_tx_busy, bb_tx_re, buffer_underrun_irq;
  logic [4:0] avs_address;
  logic [31:0] avs_writedata, avs_readdata, q;
  logic [7:0] bb_rx_data, link_quality_value, energy_level_value, rx_status_value, bb_tx_data;
  logic [3:0] trigger_phase_count;
  logic [7:0] fr [128];
  int err_count, checked, n;

  rfb_top #(.RX_VALID_CYCLES(HOLD)) i_dut (.clk(clk), .reset(reset),
    .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
    .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .sleep_state(sleep_state),
    .power_on_state(power_on_state), .mclk_1mhz_sel(mclk_1mhz_sel),
    .tx_trigger_pin(tx_trigger_pin), .master_clock_out(master_clock_out),
    .bb_rx_start(bb_rx_start), .bb_rx_we(bb_rx_we), .bb_rx_data(bb_rx_data),
    .bb_rx_meta_we(bb_rx_meta_we), .link_quality_value(link_quality_value),
    .energy_level_value(energy_level_value), .rx_status_value(rx_status_value),
    .auto_retry_tx_mode(auto_retry_tx_mode), .bb_ack_wait(bb_ack_wait),
    .bb_tx_start(bb_tx_start), .bb_tx_busy(bb_tx_busy), .bb_tx_re(bb_tx_re),
    .bb_tx_data(bb_tx_data), .buffer_underrun_irq(buffer_underrun_irq),
    .trigger_phase_count(trigger_phase_count));

  rfb_host_model i_host (.clk(clk), .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest));

  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  initial begin
    master_clock_out = 1'b0;
    #1.3;
    forever #80 master_clock_out = ~master_clock_out;
  end

  task automatic finish_test();
    if (err_count == 0 && checked > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    checked++;
    if (g !== e) begin
      err_count++;
      $display("wrong value %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic wr(input logic [4:0] a, input logic [31:0] d);
    i_host.xfer(1'b1, a, d, q);
  endtask
  task automatic rd(input logic [4:0] a, output logic [31:0] r);
    i_host.xfer(1'b0, a, 32'h0000_0000, r);
  endtask
  task automatic rchk(input string nm, input logic [4:0] a, input logic [31:0] e);
    rd(a, q);
    chk(nm, e, q);
  endtask
  task automatic urchk(input logic e);
    chk("irq pin", {31'h0, e}, {31'h0, buffer_underrun_irq});
    rd(rfb_pkg::REG_STATUS, q);
    chk("underrun bit", {31'h0, e}, {31'h0, q[rfb_pkg::STAT_UR_BIT]});
  endtask
  task automatic fill(input int l);
    fr[0] = 8'(l);
    for (int i = 1; i <= l; i++) fr[i] = 8'($urandom);
  endtask
  task automatic load(input int l);
    fill(l);
    wr(rfb_pkg::REG_FB_ADDR, 32'h0000_0000);
    for (int i = 0; i <= l; i++) wr(rfb_pkg::REG_FB_DATA, {24'h0, fr[i]});
  endtask
  task automatic rdback(input int l, input logic m);
    wr(rfb_pkg::REG_FB_ADDR, 32'h0000_0000);
    for (int i = 0; i <= l; i++) rchk("fb byte", rfb_pkg::REG_FB_DATA, {24'h0, fr[i]});
    if (m) begin
      rchk("link quality", rfb_pkg::REG_FB_DATA, {24'h0, link_quality_value});
      rchk("energy", rfb_pkg::REG_FB_DATA, {24'h0, energy_level_value});
      rchk("rx status", rfb_pkg::REG_FB_DATA, {24'h0, rx_status_value});
    end
  endtask
  // expected checksum over the payload ahead of the two checksum bytes
  function automatic logic [15:0] fcs(input int l);
    logic [15:0] c;
    c = rfb_pkg::FCS_INIT;
    for (int i = 1; i <= l - 2; i++) begin
      c = c ^ {8'h00, fr[i]};
      for (int b = 0; b < 8; b++) c = c[0] ? (c >> 1) ^ rfb_pkg::FCS_POLY : c >> 1;
    end
    return c;
  endfunction
  task automatic tx(input int l, input logic af);
    logic [15:0] c;
    logic [7:0] e;
    c = fcs(l);
    bb_tx_start <= 1'b1;
    bb_tx_busy <= 1'b1;
    @(posedge clk);
    bb_tx_start <= 1'b0;
    @(posedge clk);
    for (int i = 0; i <= l; i++) begin
      bb_tx_re <= 1'b1;
      @(posedge clk);
      bb_tx_re <= 1'b0;
      #1;
      e = (af && l >= 2 && i == l - 1) ? c[7:0] : (af && l >= 2 && i == l) ? c[15:8] : fr[i];
      chk("tx byte", {24'h0, e}, {24'h0, bb_tx_data});
      @(posedge clk);
    end
    bb_tx_busy <= 1'b0;
  endtask
  task automatic rx(input int l, input logic [7:0] x);
    bb_rx_start <= 1'b1;
    @(posedge clk);
    bb_rx_start <= 1'b0;
    bb_rx_we <= 1'b1;
    for (int i = 0; i <= l; i++) begin
      bb_rx_data <= fr[i] ^ x;
      @(posedge clk);
    end
    bb_rx_we <= 1'b0;
    bb_rx_meta_we <= 1'b1;
    @(posedge clk);
    bb_rx_meta_we <= 1'b0;
    @(posedge clk);
  endtask

  initial begin
    repeat (100000) @(posedge clk);
    err_count++;
    finish_test();
  end

  initial begin
    void'($urandom(82));
    {reset, sleep_state, power_on_state, mclk_1mhz_sel, tx_trigger_pin, bb_rx_start} = 6'h20;
    {bb_rx_we, bb_rx_meta_we, auto_retry_tx_mode, bb_ack_wait, bb_tx_start} = 5'h00;
    {bb_tx_busy, bb_tx_re} = 2'h0;
    {bb_rx_data, link_quality_value, energy_level_value, rx_status_value} = 32'h0000_0000;
    repeat (16) @(posedge clk);
    reset <= 1'b0;
    @(posedge clk);
    rchk("ctrl", rfb_pkg::REG_CTRL, 32'h0000_0000);
    rchk("status", rfb_pkg::REG_STATUS, 32'h0000_0001);
    rchk("phase", rfb_pkg::REG_PHASE, 32'h0000_0000);
    wr(5'h1c, 32'hffff_ffff);
    rchk("unmapped", 5'h1c, rfb_pkg::UNMAPPED_VALUE);
    n = $urandom_range(1, 120);
    load(n);
    wr(rfb_pkg::REG_SRAM_ADDR, 32'h0000_0000);
    rchk("len byte", rfb_pkg::REG_SRAM_DATA, {24'h0, fr[0]});
    rdback(n, 1'b0);
    urchk(1'b0);
    wr(rfb_pkg::REG_FB_ADDR, 32'h0000_007f);
    wr(rfb_pkg::REG_FB_DATA, 32'h0000_00a5);
    urchk(1'b0);
    wr(rfb_pkg::REG_FB_DATA, 32'h0000_005a);
    urchk(1'b1);
    urchk(1'b0);
    bb_tx_start <= 1'b1;
    bb_tx_busy <= 1'b1;
    @(posedge clk);
    bb_tx_start <= 1'b0;
    wr(rfb_pkg::REG_SRAM_DATA, 32'h0000_0011);
    urchk(1'b0);
    wr(rfb_pkg::REG_FB_ADDR, 32'h0000_0000);
    wr(rfb_pkg::REG_FB_DATA, 32'h0000_0011);
    urchk(1'b1);
    bb_tx_busy <= 1'b0;
    for (int a = 0; a < 2; a++) begin
      for (int k = 0; k < 2; k++) begin
        n = k ? $urandom_range(2, 120) : 1;
        load(n);
        wr(rfb_pkg::REG_CTRL, 32'(a));
        rchk("ctrl", rfb_pkg::REG_CTRL, 32'(a));
        tx(n, a[0]);
      end
    end
    n = $urandom_range(1, 120);
    fill(n);
    {link_quality_value, energy_level_value, rx_status_value} <= 24'($urandom);
    // no new reception until read done
    rx(n, 8'h00);
    rdback(n, 1'b1);
    urchk(1'b0);
    wr(rfb_pkg::REG_SRAM_ADDR, 32'h0000_0000);
    rchk("rx len", rfb_pkg::REG_SRAM_DATA, {24'h0, fr[0]});
    auto_retry_tx_mode <= 1'b1;
    bb_ack_wait <= 1'b1;
    rx(n, 8'hff);
    auto_retry_tx_mode <= 1'b0;
    bb_ack_wait <= 1'b0;
    rdback(n, 1'b0);
    wr(rfb_pkg::REG_FB_ADDR, 32'h0000_0000);
    rd(rfb_pkg::REG_FB_DATA, q);
    fill($urandom_range(1, 120));
    rx(fr[0], 8'h00);
    urchk(1'b1);
    urchk(1'b0);
    wr(rfb_pkg::REG_FB_ADDR, 32'h0000_0000);
    bb_rx_start <= 1'b1;
    @(posedge clk);
    bb_rx_start <= 1'b0;
    bb_rx_we <= 1'b1;
    bb_rx_data <= 8'h05;
    @(posedge clk);
    bb_rx_we <= 1'b0;
    rd(rfb_pkg::REG_FB_DATA, q);
    rd(rfb_pkg::REG_FB_DATA, q);
    urchk(1'b0);
    repeat (HOLD) @(posedge clk);
    rd(rfb_pkg::REG_FB_DATA, q);
    urchk(1'b1);
    bb_rx_meta_we <= 1'b1;
    @(posedge clk);
    bb_rx_meta_we <= 1'b0;
    wr(rfb_pkg::REG_SRAM_ADDR, 32'h0000_0000);
    power_on_state <= 1'b1;
    rchk("no clock", rfb_pkg::REG_SRAM_DATA, 32'h0000_0000);
    wr(rfb_pkg::REG_FB_DATA, 32'h0000_0033);
    rchk("blocked ptr", rfb_pkg::REG_FB_ADDR, 32'h0000_0003);
    mclk_1mhz_sel <= 1'b1;
    rchk("clock on", rfb_pkg::REG_SRAM_DATA, 32'h0000_0005);
    power_on_state <= 1'b0;
    sleep_state <= 1'b1;
    rchk("asleep", rfb_pkg::REG_SRAM_DATA, 32'h0000_0000);
    sleep_state <= 1'b0;
    rchk("wiped", rfb_pkg::REG_SRAM_DATA, 32'h0000_0000);
    @(posedge master_clock_out);
    repeat (30) @(posedge clk);
    tx_trigger_pin <= 1'b1;
    repeat (10) @(posedge clk);
    tx_trigger_pin <= 1'b0;
    chk("phase pin", 32'h0000_0001, {28'h0, trigger_phase_count});
    wr(rfb_pkg::REG_PHASE, 32'h0000_000f);
    rchk("phase", rfb_pkg::REG_PHASE, 32'h0000_0001);
    finish_test();
  end
endmodule
